// ---- dv/pbc_button_model.sv ----
// Push-button contact pressed by the bench's virtual user.
// Assumes the bench holds want_press high for the length of a press.
`timescale 1ns/10ps
`default_nettype none
module pbc_button_model (
   // Clock and user request
   input  wire logic pclk,
   input  wire logic want_press,
   // Contact, high while pressed
   output var  logic button_pin
);
   // The finger is sampled on the design clock edge, so the contact lags a cycle
   initial button_pin = 1'b0;
   always @(posedge pclk) button_pin <= want_press;
endmodule
`default_nettype wire

// ---- dv/pbc_classifier_bench.sv ----
// Self-checking bench of the press classifier with a random press user.
// Assumes the design, its package and header file on the include path.
`timescale 1ns/10ps
`include "pbc_consts.svh"
`default_nettype none
module pbc_classifier_bench import pbc_pkg::*; ;
   // A short millisecond keeps presses of several seconds affordable
   localparam int CPM = 4;
   localparam int HD  = 20;
   localparam int HI  = 10;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        want_press = 1'b0;
   logic        button_pin;
   logic [3:0]  swipes = 4'h0;
   logic        approach_in = 1'b0;
   logic [3:0]  page_index = 4'h0;
   logic        green_lamp;
   logic        red_lamp;
   logic        show_off_picture;
   logic        show_on_picture;
   logic        picture_invert;
   logic [12:0] event_pulse;
   logic [31:0] rd;
   logic [31:0] seed = 32'd74639;
   logic        err;
   logic        st = 1'b0;
   int          bad_count = 0;
   int          comparisons = 0;
   int          hold_n = 0;
   int          lo [5] = '{10, 30, 510, 2010, 5010};
   int          sp [5] = '{1, 440, 1480, 1490, 50};

   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (event_pulse[3] === 1'b1) hold_n++;

   pbc_classifier #(.CYCLES_PER_MS(CPM)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .button_pin(button_pin), .swipe_up_in(swipes[0]), .swipe_down_in(swipes[1]),
      .swipe_left_in(swipes[2]), .swipe_right_in(swipes[3]), .approach_in(approach_in),
      .page_index(page_index), .green_lamp(green_lamp), .red_lamp(red_lamp),
      .show_off_picture(show_off_picture), .show_on_picture(show_on_picture),
      .picture_invert(picture_invert), .event_pulse(event_pulse));
   pbc_button_model user_u (.pclk(pclk), .want_press(want_press), .button_pin(button_pin));

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function logic [31:0] exp_ev(input int ms, input pbc_mode_t m);
      exp_ev = 32'h60;
      if (m != PBC_LOCKED) begin
         exp_ev[4] = 1'b1;
         exp_ev[3] = ms > HD;
         if (ms < 500) exp_ev[0] = 1'b1;
         else if (ms < 2000) exp_ev[1] = 1'b1;
         else if (ms <= 5000) exp_ev[2] = 1'b1;
      end
   endfunction
   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) chk(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   // One press of ms milliseconds; mid is the status expected while pressed
   task trial(input int ms, input pbc_mode_t m, input logic [1:0] mid);
      int eh;
      int dh;
      hold_n = 0;
      want_press <= 1'b1;
      repeat (20) @(posedge pclk);
      rdc(12'h010, 32'h3, {30'h0, mid});
      repeat (ms * CPM - 24) @(posedge pclk);
      want_press <= 1'b0;
      repeat (30) @(posedge pclk);
      eh = (m == PBC_LOCKED || ms < HD) ? 0 : (ms - HD) / HI + 1;
      dh = hold_n - eh;
      chk({31'h0, dh >= -1 && dh <= 1}, 32'h1);
      rdc(12'h014, 32'h1fff, exp_ev(ms, m));
      apb(1'b1, 12'h014, 32'h1fff);
   endtask

   initial begin
      int          ms;
      logic [31:0] r;
      logic [5:0]  e;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h000, 32'hffffffff, 32'h0);
      rdc(12'h004, 32'hffff, 32'(`PBC_HOLD_DELAY_RST));
      rdc(12'h008, 32'hffff, 32'(`PBC_HOLD_INTVL_RST));
      apb(1'b0, 12'h01c, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      for (int m = 2; m >= 0; m--) begin
         apb(1'b1, 12'h000, 32'(m));
         rdc(12'h000, 32'hffffffff, 32'(m));
      end
      apb(1'b1, 12'h004, 32'(HD));
      apb(1'b1, 12'h008, 32'(HI));
      rdc(12'h004, 32'hffff, 32'(HD));
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h018, 32'hf);
      // A press shorter than the hold delay, one random press per class, then one past the long-press limit
      for (int i = 0; i < 5; i++) begin
         ms = lo[i] + int'(xs() % sp[i]);
         trial(ms, PBC_TOGGLING, {1'b1, st});
         st = ~st;
         rdc(12'h010, 32'h3, {31'h0, st});
         chk({29'h0, show_off_picture, show_on_picture, picture_invert}, {29'h0, ~st, st, 1'b1});
      end
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h014, 32'h1fff);
      trial(10, PBC_MOMENTARY, 2'b11);
      rdc(12'h010, 32'h3, 32'h0);
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h000, 32'h3);
      rdc(12'h000, 32'hffffffff, 32'h2);
      trial(600, PBC_LOCKED, 2'b10);
      rdc(12'h010, 32'h3, 32'h0);
      chk({29'h0, show_off_picture, show_on_picture, picture_invert}, 32'h0);
      apb(1'b1, 12'h00c, 32'h1);
      rdc(12'h010, 32'h1c, 32'h4);
      apb(1'b1, 12'h00c, 32'h2);
      rdc(12'h010, 32'h8, 32'h8);
      apb(1'b1, 12'h00c, 32'h4);
      rdc(12'h010, 32'h1c, 32'h0);
      for (int b = 3; b <= 4; b++) begin
         apb(1'b1, 12'h00c, 32'h1 << b);
         rdc(12'h010, 32'h10, 32'h10);
         repeat (300 * CPM) @(posedge pclk);
         rdc(12'h010, 32'hc, 32'h0);
         repeat (250 * CPM) @(posedge pclk);
         rdc(12'h010, 32'hc, 32'h4 << (b - 3));
         repeat (1460 * CPM) @(posedge pclk);
         rdc(12'h010, 32'h1c, 32'h0);
      end
      for (int i = 0; i < 24; i++) begin
         @(posedge pclk);
         r = xs();
         e = {r[8:5] != page_index, r[4] & ~approach_in, r[3:0]};
         swipes <= r[3:0];
         approach_in <= r[4];
         page_index <= r[8:5];
         @(posedge pclk);
         #1;
         chk({26'h0, event_pulse[12:7]}, {26'h0, e});
      end
      summarize;
   end
   initial begin
      repeat (90000) @(posedge pclk);
      bad_count++;
      summarize;
   end
endmodule
`default_nettype wire

// ---- dv/pbc_classifier_checker.sv ----
// Port-level assertions for the press classifier.
// Assumes it is bound to pbc_classifier; one clock, asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module pbc_classifier_checker #(
   parameter int CYCLES_PER_MS = 40000
) (
   // Clock, reset and APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        pready,
   // Panel side
   input  wire logic        button_pin,
   input  wire logic        swipe_up_in,
   input  wire logic        swipe_down_in,
   input  wire logic        swipe_left_in,
   input  wire logic        swipe_right_in,
   input  wire logic        approach_in,
   input  wire logic [3:0]  page_index,
   input  wire logic        green_lamp,
   input  wire logic        red_lamp,
   input  wire logic [12:0] event_pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence lamp_wr;
      psel && penable && pready && pwrite && paddr == 12'h00c;
   endsequence
   sequence ok_wr;
      lamp_wr ##0 (pwdata[3] && !pwdata[2]);
   endsequence
   sequence bad_wr;
      lamp_wr ##0 (pwdata[4] && !pwdata[3] && !pwdata[2]);
   endsequence
   chk_success_red_dark: assert property (ok_wr |=> ##[0:3] green_lamp ##1 !red_lamp [*8])
      else $error("red lit in success blink");
   chk_failure_green_dark: assert property (bad_wr |=> ##[0:3] red_lamp ##1 !green_lamp [*8])
      else $error("green lit in failure blink");
   chk_green_steady: assert property (lamp_wr ##0 pwdata[4:0] == 5'h01 |=> ##[0:3] green_lamp [*4])
      else $error("green not steady");
   chk_red_steady: assert property (lamp_wr ##0 pwdata[4:0] == 5'h02 |=> ##[0:3] red_lamp [*4])
      else $error("red not steady");
   chk_lamps_dark: assert property (lamp_wr ##0 pwdata[2] |=> ##[0:3] (!green_lamp && !red_lamp) [*4])
      else $error("lamps not off");
   chk_level_rise: assert property ($rose(button_pin) |-> ##[1:8] event_pulse[5])
      else $error("no level high event");
   chk_level_fall: assert property ($fell(button_pin) |-> ##[1:8] event_pulse[6])
      else $error("no level low event");
   chk_swipe_each: assert property (|{swipe_right_in, swipe_left_in, swipe_down_in, swipe_up_in} |=>
      event_pulse[10:7] == $past({swipe_right_in, swipe_left_in, swipe_down_in, swipe_up_in}))
      else $error("swipe event wrong");
   chk_approach_rise: assert property ($rose(approach_in) |=> event_pulse[11])
      else $error("no approach event");
   chk_page_change: assert property (page_index != $past(page_index) |=> event_pulse[12])
      else $error("no page event");
   chk_duration_once: assert property (|event_pulse[2:0] |-> event_pulse[6] && $onehot(event_pulse[2:0]))
      else $error("duration event not single at release");
   chk_hold_release: assert property (event_pulse[3] |-> !event_pulse[6])
      else $error("hold event at release");
endmodule
bind pbc_classifier pbc_classifier_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .button_pin(button_pin),
   .swipe_up_in(swipe_up_in), .swipe_down_in(swipe_down_in), .swipe_left_in(swipe_left_in),
   .swipe_right_in(swipe_right_in), .approach_in(approach_in), .page_index(page_index),
   .green_lamp(green_lamp), .red_lamp(red_lamp), .event_pulse(event_pulse));
`default_nettype wire

// ---- include/pbc_consts.svh ----
// Offsets, field positions, reset values and timing counts of the press classifier.
// Assumes a 40 MHz APB clock and a 32-bit APB data path.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH
`define PBC_CLK_PERIOD_NS   25
`define PBC_MS_NS           1000000
`define PBC_CLICK_MAX_MS    16'd500
`define PBC_SHORT_MAX_MS    16'd2000
`define PBC_LONG_MAX_MS     16'd5000
`define PBC_BLINK_TOTAL_MS  11'd2000
`define PBC_BLINK_PERIOD_MS 9'd500
`define PBC_BLINK_ON_MS     9'd250
`define PBC_HOLD_DELAY_RST  16'd1000
`define PBC_HOLD_INTVL_RST  16'd250
`define PBC_OFF_CTRL        3'd0
`define PBC_OFF_HOLD_DELAY  3'd1
`define PBC_OFF_HOLD_INTVL  3'd2
`define PBC_OFF_LAMP        3'd3
`define PBC_OFF_STATUS      3'd4
`define PBC_OFF_EVENT       3'd5
`define PBC_OFF_PICTURE     3'd6
`define PBC_LAMP_GREEN      0
`define PBC_LAMP_RED        1
`define PBC_LAMP_OFF        2
`define PBC_LAMP_SUCCESS    3
`define PBC_LAMP_FAILURE    4
`define PBC_PIC_OFF_SET     0
`define PBC_PIC_ON_SET      1
`define PBC_PIC_OFF_INV     2
`define PBC_PIC_ON_INV      3
`define PBC_EV_W            13
`endif

// ---- include/pbc_pkg.sv ----
// Types shared by the press classifier.
// Assumes nothing beyond a SystemVerilog tool.
`default_nettype none
package pbc_pkg;
   typedef enum logic [1:0] {
      PBC_MOMENTARY = 2'h0,
      PBC_TOGGLING  = 2'h1,
      PBC_LOCKED    = 2'h2
   } pbc_mode_t;
   typedef enum logic [1:0] {
      PBC_IDLE    = 2'h0,
      PBC_DOWN    = 2'h1,
      PBC_HOLDING = 2'h3
   } pbc_press_t;
   typedef enum logic [3:0] {
      PBC_EV_CLICK = 4'h0, PBC_EV_SHORT = 4'h1, PBC_EV_LONG = 4'h2,
      PBC_EV_HOLD = 4'h3, PBC_EV_TOGGLE = 4'h4, PBC_EV_HIGH = 4'h5,
      PBC_EV_LOW = 4'h6, PBC_EV_UP = 4'h7, PBC_EV_DOWN = 4'h8,
      PBC_EV_LEFT = 4'h9, PBC_EV_RIGHT = 4'ha, PBC_EV_APPROACH = 4'hb,
      PBC_EV_PAGE = 4'hc
   } pbc_event_t;
endpackage
`default_nettype wire

// ---- rtl/pbc_classifier.sv ----
// Button press classifier with lamp control, reached over APB.
// Assumes a free-running pclk, a raw button pin and same-clock panel strobes.
`timescale 1ns/10ps
`include "pbc_consts.svh"
`default_nettype none

// What this block does
// - Hold and report mode 0/1/2.
// - Mode write applies new mode.
// - Report button state as one bit.
// - Hold event after delay, then every interval.
// - Hold delay and interval writable, in ms.
// - Click for release under 500 ms.
// - Short press for 500 to 2000 ms.
// - Long press for 2000 to 5000 ms.
// - Toggle event on every state change.
// - Level-high event on input rising.
// - Level-low event on input falling.
// - Success blinks green two seconds, red off.
// - Failure blinks red two seconds, green off.
// - Green-on command lights green steadily.
// - Red-on command lights red steadily.
// - Lamps-off command darkens every lamp.
// - Off picture shown when off and not locked, over caption.
// - Toggling mode shows on picture when on.
// - One event per swipe direction.
// - Approach event on proximity detection.
// - Page-change event when page changes.
module pbc_classifier
   import pbc_pkg::*;
#(
   parameter int CYCLES_PER_MS = `PBC_MS_NS / `PBC_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Button pin and panel inputs
   input  wire logic        button_pin,
   input  wire logic        swipe_up_in,
   input  wire logic        swipe_down_in,
   input  wire logic        swipe_left_in,
   input  wire logic        swipe_right_in,
   input  wire logic        approach_in,
   input  wire logic [3:0]  page_index,
   // Lamps and picture choice
   output logic             green_lamp,
   output logic             red_lamp,
   output logic             show_off_picture,
   output logic             show_on_picture,
   output logic             picture_invert,
   // One-cycle event pulses, bit order as pbc_event_t
   output logic [12:0]      event_pulse
);

   // Millisecond time base
   logic [15:0]      div_q;
   logic             tick_q;
   wire logic        div_wrap = (div_q == 16'(CYCLES_PER_MS - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         div_q  <= div_wrap ? 16'h0000 : div_q + 16'h0001;
         tick_q <= div_wrap;
      end
   end

   // Pin synchroniser; a change counts once stages two and three agree
   logic             sync1_q;
   logic             sync2_q;
   logic             sync3_q;
   logic             level_q;
   wire logic        level_rise = (sync2_q == sync3_q) && sync2_q && !level_q;
   wire logic        level_fall = (sync2_q == sync3_q) && !sync2_q && level_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         sync1_q <= button_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            level_q <= sync2_q;
         end
      end
   end

   // APB decode
   logic             pready_q;
   logic             pslverr_q;
   logic [31:0]      prdata_q;
   wire logic        apb_access = psel && penable;
   wire logic [2:0]  reg_idx    = paddr[4:2];
   wire logic        reg_mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0) && (reg_idx <= `PBC_OFF_PICTURE);
   wire logic        wr_done    = apb_access && pready_q && pwrite && reg_mapped;
   wire logic        wr_ctrl    = wr_done && (reg_idx == `PBC_OFF_CTRL);
   wire logic        wr_delay   = wr_done && (reg_idx == `PBC_OFF_HOLD_DELAY);
   wire logic        wr_intvl   = wr_done && (reg_idx == `PBC_OFF_HOLD_INTVL);
   wire logic        wr_lamp    = wr_done && (reg_idx == `PBC_OFF_LAMP);
   wire logic        wr_event   = wr_done && (reg_idx == `PBC_OFF_EVENT);
   wire logic        wr_pict    = wr_done && (reg_idx == `PBC_OFF_PICTURE);

   // Control registers
   pbc_mode_t        mode_q;
   logic [15:0]      hold_start_delay_ms;
   logic [15:0]      hold_repeat_interval_ms;
   logic [3:0]       pict_q;
   wire logic        button_mode_write          = wr_ctrl && (pwdata[1:0] != 2'h3);
   wire logic        hold_start_delay_write     = wr_delay;
   wire logic        hold_repeat_interval_write = wr_intvl;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q                  <= PBC_MOMENTARY;
         hold_start_delay_ms     <= `PBC_HOLD_DELAY_RST;
         hold_repeat_interval_ms <= `PBC_HOLD_INTVL_RST;
         pict_q                  <= 4'h0;
      end else begin
         // Code 3 is not a mode, so such a write leaves the mode alone
         if (button_mode_write) begin
            mode_q <= pbc_mode_t'(pwdata[1:0]);
         end
         if (hold_start_delay_write) begin
            hold_start_delay_ms <= pwdata[15:0];
         end
         if (hold_repeat_interval_write) begin
            hold_repeat_interval_ms <= pwdata[15:0];
         end
         if (wr_pict) begin
            pict_q <= pwdata[3:0];
         end
      end
   end

   // Press timing and classification
   pbc_press_t       press_q;
   logic [15:0]      press_ms_q;
   logic [15:0]      hold_ms_q;
   logic             state_q;
   wire logic        locked     = (mode_q == PBC_LOCKED);
   wire logic        press_go   = level_rise && !locked;
   wire logic        press_end  = level_fall && (press_q != PBC_IDLE);
   wire logic [15:0] hold_next  = hold_ms_q + 16'h0001;
   wire logic [15:0] hold_goal  = (press_q == PBC_DOWN) ? hold_start_delay_ms : hold_repeat_interval_ms;
   wire logic        hold_fire  = tick_q && (press_q != PBC_IDLE) && level_q && (hold_next >= hold_goal);
   wire logic        is_click   = press_end && (press_ms_q < `PBC_CLICK_MAX_MS);
   wire logic        is_short   = press_end && (press_ms_q >= `PBC_CLICK_MAX_MS) && (press_ms_q < `PBC_SHORT_MAX_MS);
   wire logic        is_long    = press_end && (press_ms_q >= `PBC_SHORT_MAX_MS) && (press_ms_q <= `PBC_LONG_MAX_MS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         press_q    <= PBC_IDLE;
         press_ms_q <= 16'h0000;
         hold_ms_q  <= 16'h0000;
      end else begin
         case (press_q)
            PBC_IDLE: begin
               if (press_go) begin
                  press_q    <= PBC_DOWN;
                  press_ms_q <= 16'h0000;
                  hold_ms_q  <= 16'h0000;
               end
            end
            PBC_DOWN, PBC_HOLDING: begin
               if (press_end) begin
                  press_q <= PBC_IDLE;
               end else if (tick_q) begin
                  // Saturate so very long presses never wrap into a click
                  if (press_ms_q != 16'hffff) begin
                     press_ms_q <= press_ms_q + 16'h0001;
                  end
                  if (hold_fire) begin
                     press_q   <= PBC_HOLDING;
                     hold_ms_q <= 16'h0000;
                  end else begin
                     hold_ms_q <= hold_next;
                  end
               end
            end
            default: begin
               press_q <= PBC_IDLE;
            end
         endcase
      end
   end

   // Button state
   logic             state_d;

   always_comb begin
      state_d = state_q;
      case (mode_q)
         PBC_MOMENTARY: state_d = level_q;
         PBC_TOGGLING: begin
            if (press_end) begin
               state_d = !state_q;
            end
         end
         default: state_d = state_q;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Panel strobes; page index is watched for any change
   logic             approach_q;
   logic [3:0]       page_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         approach_q <= 1'b0;
         page_q     <= 4'h0;
      end else begin
         approach_q <= approach_in;
         page_q     <= page_index;
      end
   end

   logic [12:0]      ev_d;

   always_comb begin
      ev_d                  = 13'h0000;
      ev_d[PBC_EV_CLICK]    = is_click;
      ev_d[PBC_EV_SHORT]    = is_short;
      ev_d[PBC_EV_LONG]     = is_long;
      ev_d[PBC_EV_HOLD]     = hold_fire && !press_end;
      ev_d[PBC_EV_TOGGLE]   = (state_d != state_q);
      ev_d[PBC_EV_HIGH]     = level_rise;
      ev_d[PBC_EV_LOW]      = level_fall;
      ev_d[PBC_EV_UP]       = swipe_up_in;
      ev_d[PBC_EV_DOWN]     = swipe_down_in;
      ev_d[PBC_EV_LEFT]     = swipe_left_in;
      ev_d[PBC_EV_RIGHT]    = swipe_right_in;
      ev_d[PBC_EV_APPROACH] = approach_in && !approach_q;
      ev_d[PBC_EV_PAGE]     = (page_index != page_q);
   end

   // Sticky copy of the events; a new event wins over its clear
   logic [12:0]      ev_q;
   logic [12:0]      sticky_q;
   wire logic [12:0] ev_clear = wr_event ? pwdata[12:0] : 13'h0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_q     <= 13'h0000;
         sticky_q <= 13'h0000;
      end else begin
         ev_q     <= ev_d;
         sticky_q <= (sticky_q & ~ev_clear) | ev_d;
      end
   end

   // Lamps
   logic             steady_green_q;
   logic             steady_red_q;
   logic             blink_q;
   logic             blink_green_q;
   logic [10:0]      blink_ms_q;
   logic [8:0]       phase_ms_q;
   logic             green_q;
   logic             red_q;
   wire logic        green_lamp_on_cmd  = wr_lamp && pwdata[`PBC_LAMP_GREEN];
   wire logic        red_lamp_on_cmd    = wr_lamp && pwdata[`PBC_LAMP_RED];
   wire logic        all_lamps_off_cmd  = wr_lamp && pwdata[`PBC_LAMP_OFF];
   wire logic        success_blink_cmd  = wr_lamp && pwdata[`PBC_LAMP_SUCCESS];
   wire logic        failure_blink_cmd  = wr_lamp && pwdata[`PBC_LAMP_FAILURE];
   wire logic        blink_lit          = blink_q && (phase_ms_q < `PBC_BLINK_ON_MS);
   wire logic        blink_last         = tick_q && (blink_ms_q == `PBC_BLINK_TOTAL_MS - 11'd1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         steady_green_q <= 1'b0;
         steady_red_q   <= 1'b0;
         blink_q        <= 1'b0;
         blink_green_q  <= 1'b0;
         blink_ms_q     <= 11'h000;
         phase_ms_q     <= 9'h000;
      end else if (all_lamps_off_cmd) begin
         steady_green_q <= 1'b0;
         steady_red_q   <= 1'b0;
         blink_q        <= 1'b0;
      end else if (success_blink_cmd || failure_blink_cmd) begin
         // A blink starts from the lit half and clears both steady lamps
         steady_green_q <= 1'b0;
         steady_red_q   <= 1'b0;
         blink_q        <= 1'b1;
         blink_green_q  <= success_blink_cmd;
         blink_ms_q     <= 11'h000;
         phase_ms_q     <= 9'h000;
      end else if (green_lamp_on_cmd || red_lamp_on_cmd) begin
         steady_green_q <= steady_green_q | green_lamp_on_cmd;
         steady_red_q   <= steady_red_q | red_lamp_on_cmd;
         blink_q        <= 1'b0;
      end else if (blink_q && tick_q) begin
         blink_q    <= !blink_last;
         blink_ms_q <= blink_ms_q + 11'd1;
         phase_ms_q <= (phase_ms_q == `PBC_BLINK_PERIOD_MS - 9'd1) ? 9'h000 : phase_ms_q + 9'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         green_q <= 1'b0;
         red_q   <= 1'b0;
      end else begin
         green_q <= blink_q ? (blink_lit && blink_green_q) : steady_green_q;
         red_q   <= blink_q ? (blink_lit && !blink_green_q) : steady_red_q;
      end
   end

   // Picture choice; a set picture takes priority over the caption
   logic             show_off_q;
   logic             show_on_q;
   logic             invert_q;
   wire logic        want_on  = (mode_q == PBC_TOGGLING) && state_q && pict_q[`PBC_PIC_ON_SET];
   wire logic        want_off = !locked && !state_q && pict_q[`PBC_PIC_OFF_SET];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         show_off_q <= 1'b0;
         show_on_q  <= 1'b0;
         invert_q   <= 1'b0;
      end else begin
         show_on_q  <= want_on;
         show_off_q <= want_off;
         invert_q   <= (want_on && pict_q[`PBC_PIC_ON_INV]) || (want_off && pict_q[`PBC_PIC_OFF_INV]);
      end
   end

   // Register read mux
   logic [31:0]      rdata;

   always_comb begin
      rdata = 32'h0000_0000;
      case (reg_idx)
         `PBC_OFF_CTRL:       rdata[1:0]  = mode_q;
         `PBC_OFF_HOLD_DELAY: rdata[15:0] = hold_start_delay_ms;
         `PBC_OFF_HOLD_INTVL: rdata[15:0] = hold_repeat_interval_ms;
         `PBC_OFF_LAMP:       rdata[1:0]  = {red_q, green_q};
         `PBC_OFF_STATUS:     rdata[4:0]  = {blink_q, red_q, green_q, level_q, state_q};
         `PBC_OFF_EVENT:      rdata[12:0] = sticky_q;
         `PBC_OFF_PICTURE:    rdata[3:0]  = pict_q;
         default:             rdata       = 32'h0000_0000;
      endcase
   end

   // One wait state lets read data come from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= apb_access && !pready_q;
         pslverr_q <= apb_access && !pready_q && !reg_mapped;
         prdata_q  <= (apb_access && !pready_q && !pwrite && reg_mapped) ? rdata : 32'h0000_0000;
      end
   end

   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;
   assign green_lamp       = green_q;
   assign red_lamp         = red_q;
   assign show_off_picture = show_off_q;
   assign show_on_picture  = show_on_q;
   assign picture_invert   = invert_q;
   assign event_pulse      = ev_q;

endmodule

`default_nettype wire
